// ==== include/tmr_pkg.sv ====
`default_nettype none
package tmr_pkg;
    localparam int TMR_DW     = 8;
    localparam int TMR_AW     = 8;
    localparam int TMR_NCH    = 4;
    localparam int TMR_NPAIR  = 2;
    localparam int TMR_PRESC_W = 11;

    // register byte addresses
    localparam logic [7:0] TMR_ADDR_RUN     = 8'h20;
    localparam logic [7:0] TMR_ADDR_PERIOD0 = 8'h22;
    localparam logic [7:0] TMR_ADDR_PERIOD1 = 8'h23;
    localparam logic [7:0] TMR_ADDR_MODE_A  = 8'h24;
    localparam logic [7:0] TMR_ADDR_FLOPC   = 8'h25;
    localparam logic [7:0] TMR_ADDR_PERIOD2 = 8'h26;
    localparam logic [7:0] TMR_ADDR_PERIOD3 = 8'h27;
    localparam logic [7:0] TMR_ADDR_MODE_B  = 8'h28;
    localparam logic [7:0] TMR_ADDR_BUFC    = 8'h29;
    localparam logic [7:0] TMR_ADDR_STATUS  = 8'h2a;
    localparam logic [7:0] TMR_PERIOD_ADDR [TMR_NCH] = '{
        TMR_ADDR_PERIOD0, TMR_ADDR_PERIOD1,
        TMR_ADDR_PERIOD2, TMR_ADDR_PERIOD3};
    localparam logic [7:0] TMR_MODE_ADDR [TMR_NPAIR] = '{
        TMR_ADDR_MODE_A, TMR_ADDR_MODE_B};

    // reset values
    localparam logic [7:0] TMR_RUN_RST   = 8'h00;
    localparam logic [7:0] TMR_MODE_RST  = 8'h00;
    localparam logic [7:0] TMR_FLOPC_RST = 8'h33;
    localparam logic [7:0] TMR_BUFC_RST  = 8'h00;
    localparam logic [7:0] TMR_ZERO      = 8'h00;
    localparam logic [7:0] TMR_ONE       = 8'h01;

    // field positions
    localparam int TMR_RUN_PRESC_BIT = 7;
    localparam int TMR_MODE_LCLK_LSB = 0;
    localparam int TMR_MODE_UCLK_LSB = 2;
    localparam int TMR_MODE_OP_LSB   = 4;
    localparam int TMR_MODE_PWMN_LSB = 6;
    localparam int TMR_FLOPC_PAIR_STRIDE = 4;
    localparam int TMR_FLOPC_CMD_LSB = 0;
    localparam int TMR_FLOPC_INV_BIT = 2;
    localparam int TMR_FLOPC_SRC_BIT = 3;
    localparam logic [7:0] TMR_FLOPC_CMD_MASK = 8'h33;

    // prescaler tap widths: div8, div32, div128, div2048
    localparam int TMR_TAP_DIV8    = 3;
    localparam int TMR_TAP_DIV32   = 5;
    localparam int TMR_TAP_DIV128  = 7;
    localparam int TMR_TAP_DIV2048 = 11;

    // pwm cycle limits for n = 6, 7, 8 (8 wraps to zero)
    localparam logic [7:0] TMR_PWM6_LIMIT = 8'h40;
    localparam logic [7:0] TMR_PWM7_LIMIT = 8'h80;
    localparam logic [7:0] TMR_PWM8_LIMIT = 8'h00;

    typedef enum logic [1:0] {
        TMR_FF_TOGGLE = 2'h0,
        TMR_FF_SET    = 2'h1,
        TMR_FF_CLEAR  = 2'h2,
        TMR_FF_KEEP   = 2'h3
    } tmr_ff_cmd_t;

    typedef enum logic [1:0] {
        TMR_OP_8BIT = 2'h0,
        TMR_OP_RSVD = 2'h1,
        TMR_OP_PPG  = 2'h2,
        TMR_OP_PWM  = 2'h3
    } tmr_op_t;
endpackage
`default_nettype wire

// ==== include/tmr_chan_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface tmr_chan_if;
    logic                       tick;
    logic                       run;
    logic                       wr;
    logic [tmr_pkg::TMR_DW-1:0] wdata;
    logic                       buf_en;
    logic                       cyc_use;
    logic [tmr_pkg::TMR_DW-1:0] cyc_val;
    logic [tmr_pkg::TMR_DW-1:0] count;
    logic [tmr_pkg::TMR_DW-1:0] period;
    logic                       match;
    logic                       cyc_evt;

    modport chan (input tick, run, wr, wdata, buf_en, cyc_use, cyc_val,
                  output count, period, match, cyc_evt);
    modport ctl (output tick, run, wr, wdata, buf_en, cyc_use, cyc_val,
                 input count, period, match, cyc_evt);
endinterface
`default_nettype wire

// ==== logic/tmr_chan.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmr_chan (
    tmr_chan_if.chan     ch,
    input wire logic     sys_clk,
    input wire logic     reset_n
);
    import tmr_pkg::*;

    logic [TMR_DW-1:0] count_q;
    logic [TMR_DW-1:0] count_d;
    logic [TMR_DW-1:0] period_q;
    logic [TMR_DW-1:0] period_d;
    logic [TMR_DW-1:0] buf_q;
    logic [TMR_DW-1:0] buf_d;
    logic [TMR_DW-1:0] next_val;
    logic              step;
    logic              hit;
    logic              cyc;

    // match is taken on the incremented value, so a zero period hits on wrap
    always_comb
    begin
        step     = ch.run && ch.tick;
        next_val = count_q + TMR_ONE;
        hit      = step && (next_val == period_q);
        cyc      = step && ch.cyc_use && (next_val == ch.cyc_val);
        count_d  = count_q;
        if (!ch.run)
            count_d = TMR_ZERO;
        else if (cyc || (hit && !ch.cyc_use))
            count_d = TMR_ZERO;
        else if (step)
            count_d = next_val;
        period_d = period_q;
        buf_d    = buf_q;
        if (cyc && ch.buf_en)
            period_d = buf_q;
        if (ch.wr)
        begin
            buf_d = ch.wdata;
            if (!ch.buf_en)
                period_d = ch.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_q  <= TMR_ZERO;
            period_q <= TMR_ZERO;
            buf_q    <= TMR_ZERO;
        end
        else
        begin
            count_q  <= count_d;
            period_q <= period_d;
            buf_q    <= buf_d;
        end
    end

    assign ch.count   = count_q;
    assign ch.period  = period_q;
    assign ch.match   = hit;
    assign ch.cyc_evt = cyc;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    AST_MATCH_CLEARS: assert property (
        hit && !ch.cyc_use |=> count_q == TMR_ZERO)
        else $error("counter not cleared after match");
    AST_ZERO_PERIOD_OVF: assert property (
        step && period_q == TMR_ZERO && count_q == 8'hff |-> hit)
        else $error("zero period did not match on overflow");
    AST_STOP_CLEARS: assert property (
        !ch.run |=> count_q == TMR_ZERO)
        else $error("stopped counter not zero");
    AST_COUNT_STEP: assert property (
        step && !hit && !cyc |=> count_q == $past(count_q) + TMR_ONE)
        else $error("counter did not step by one");
    AST_BUF_WRITE: assert property (
        ch.wr && ch.buf_en && !cyc |=>
            period_q == $past(period_q) && buf_q == $past(ch.wdata))
        else $error("buffered write reached period");
    AST_BUF_LOAD: assert property (
        cyc && ch.buf_en && !ch.wr |=> period_q == $past(buf_q))
        else $error("buffer not loaded at cycle end");
endmodule
`default_nettype wire

// ==== logic/tmr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmr_top (
    input  wire logic                       sys_clk,
    input  wire logic                       reset_n,
    input  wire logic [tmr_pkg::TMR_AW-1:0] reg_addr,
    input  wire logic [tmr_pkg::TMR_DW-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output var  logic [tmr_pkg::TMR_DW-1:0] reg_rdata,
    output var  logic                       timer0_irq,
    output var  logic                       timer1_irq,
    output var  logic                       timer2_irq,
    output var  logic                       timer3_irq,
    output var  logic                       pair_a_output_pin,
    output var  logic                       pair_b_output_pin
);
    import tmr_pkg::*;

    function automatic logic [1:0] field2(
        input logic [TMR_DW-1:0] v,
        input int                lsb
    );
        return 2'(v >> lsb);
    endfunction

    function automatic logic tap_hit(
        input logic [TMR_PRESC_W-1:0] cnt,
        input int                     k
    );
        logic [TMR_PRESC_W-1:0] m;
        m = TMR_PRESC_W'((1 << k) - 1);
        return (cnt & m) == m;
    endfunction

    function automatic logic [TMR_DW-1:0] pwm_limit(
        input logic [1:0] nsel
    );
        case (nsel)
            2'h0:    return TMR_PWM6_LIMIT;
            2'h1:    return TMR_PWM7_LIMIT;
            default: return TMR_PWM8_LIMIT;
        endcase
    endfunction

    logic [TMR_DW-1:0]      run_q;
    logic [TMR_DW-1:0]      run_d;
    logic [TMR_DW-1:0]      mode_q [TMR_NPAIR];
    logic [TMR_DW-1:0]      mode_d [TMR_NPAIR];
    logic [TMR_DW-1:0]      flopc_q;
    logic [TMR_DW-1:0]      flopc_d;
    logic [TMR_DW-1:0]      bufc_q;
    logic [TMR_DW-1:0]      bufc_d;
    logic [TMR_PRESC_W-1:0] presc_q;
    logic [TMR_PRESC_W-1:0] presc_d;
    logic [TMR_NPAIR-1:0]   flop_q;
    logic [TMR_NPAIR-1:0]   flop_d;
    logic [TMR_NCH-1:0]     irq_q;
    logic [TMR_NCH-1:0]     irq_d;
    logic [TMR_DW-1:0]      rdata_q;
    logic [TMR_DW-1:0]      rdata_d;

    logic                   prun;
    logic                   t_div8;
    logic                   t_div32;
    logic                   t_div128;
    logic                   t_div2048;
    logic [TMR_NCH-1:0]     tick_w;
    logic [TMR_NCH-1:0]     chrun_w;
    logic [TMR_NCH-1:0]     bufen_w;
    logic [TMR_NCH-1:0]     cycuse_w;
    logic [TMR_DW-1:0]      cycval_w [TMR_NCH];
    logic [TMR_NCH-1:0]     match_w;
    logic [TMR_NCH-1:0]     cyc_w;
    logic [TMR_DW-1:0]      period_w [TMR_NCH];
    logic                   flopc_wr;

    assign flopc_wr = reg_wr && reg_addr == TMR_ADDR_FLOPC;

    // control registers
    always_comb
    begin
        run_d   = run_q;
        mode_d  = mode_q;
        flopc_d = flopc_q;
        bufc_d  = bufc_q;
        if (reg_wr)
        begin
            case (reg_addr)
                TMR_ADDR_RUN:    run_d     = reg_wdata;
                TMR_ADDR_MODE_A: mode_d[0] = reg_wdata;
                TMR_ADDR_MODE_B: mode_d[1] = reg_wdata;
                // command fields act once and read back as keep
                TMR_ADDR_FLOPC:  flopc_d   = reg_wdata | TMR_FLOPC_CMD_MASK;
                TMR_ADDR_BUFC:   bufc_d    = reg_wdata;
                default:         run_d     = run_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            run_q     <= TMR_RUN_RST;
            mode_q[0] <= TMR_MODE_RST;
            mode_q[1] <= TMR_MODE_RST;
            flopc_q   <= TMR_FLOPC_RST;
            bufc_q    <= TMR_BUFC_RST;
        end
        else
        begin
            run_q   <= run_d;
            mode_q  <= mode_d;
            flopc_q <= flopc_d;
            bufc_q  <= bufc_d;
        end
    end

    // prescaler and its taps
    assign prun = run_q[TMR_RUN_PRESC_BIT];

    always_comb
    begin
        presc_d   = prun ? presc_q + 1'b1 : '0;
        t_div8    = prun && tap_hit(presc_q, TMR_TAP_DIV8);
        t_div32   = prun && tap_hit(presc_q, TMR_TAP_DIV32);
        t_div128  = prun && tap_hit(presc_q, TMR_TAP_DIV128);
        t_div2048 = prun && tap_hit(presc_q, TMR_TAP_DIV2048);
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            presc_q <= '0;
        else
            presc_q <= presc_d;
    end

    // per-pair clock selection, mode and channel controls
    always_comb
    begin
        for (int p = 0; p < TMR_NPAIR; p++)
        begin
            case (field2(mode_q[p], TMR_MODE_LCLK_LSB))
                2'h1:    tick_w[2*p] = t_div32;
                2'h2:    tick_w[2*p] = t_div128;
                default: tick_w[2*p] = t_div8;
            endcase
            case (field2(mode_q[p], TMR_MODE_UCLK_LSB))
                2'h0:    tick_w[2*p+1] = match_w[2*p];
                2'h1:    tick_w[2*p+1] = t_div8;
                2'h2:    tick_w[2*p+1] = t_div128;
                default: tick_w[2*p+1] = t_div2048;
            endcase
            chrun_w[2*p]    = run_q[2*p];
            chrun_w[2*p+1]  = run_q[2*p+1];
            bufen_w[2*p]    = bufc_q[p];
            bufen_w[2*p+1]  = 1'b0;
            cycuse_w[2*p]   = 1'b0;
            cycuse_w[2*p+1] = 1'b0;
            cycval_w[2*p]   = TMR_ZERO;
            cycval_w[2*p+1] = TMR_ZERO;
            case (tmr_op_t'(field2(mode_q[p], TMR_MODE_OP_LSB)))
                TMR_OP_PWM:
                begin
                    cycuse_w[2*p] = 1'b1;
                    cycval_w[2*p] = pwm_limit(
                        field2(mode_q[p], TMR_MODE_PWMN_LSB));
                end
                TMR_OP_PPG:
                begin
                    // the upper period sets the cycle; upper timer idles
                    cycuse_w[2*p]  = 1'b1;
                    cycval_w[2*p]  = period_w[2*p+1];
                    chrun_w[2*p+1] = 1'b0;
                end
                default: cycuse_w[2*p] = 1'b0;
            endcase
        end
    end

    tmr_chan_if ch [TMR_NCH] ();

    genvar gi;
    generate
        for (gi = 0; gi < TMR_NCH; gi++)
        begin : g_ch
            assign ch[gi].tick    = tick_w[gi];
            assign ch[gi].run     = chrun_w[gi];
            assign ch[gi].wr      = reg_wr &&
                                    reg_addr == TMR_PERIOD_ADDR[gi];
            assign ch[gi].wdata   = reg_wdata;
            assign ch[gi].buf_en  = bufen_w[gi];
            assign ch[gi].cyc_use = cycuse_w[gi];
            assign ch[gi].cyc_val = cycval_w[gi];
            assign match_w[gi]    = ch[gi].match;
            assign cyc_w[gi]      = ch[gi].cyc_evt;
            assign period_w[gi]   = ch[gi].period;
            tmr_chan u_chan (
                .ch      (ch[gi]),
                .sys_clk (sys_clk),
                .reset_n (reset_n)
            );
        end
    endgenerate

    // output flops: a software command overrides a same-cycle match toggle
    always_comb
    begin
        for (int p = 0; p < TMR_NPAIR; p++)
        begin
            logic [TMR_DW-1:0] fc;
            logic              evt;
            fc  = flopc_q >> (p * TMR_FLOPC_PAIR_STRIDE);
            evt = 1'b0;
            if (cycuse_w[2*p])
                evt = match_w[2*p] || cyc_w[2*p];
            else if (fc[TMR_FLOPC_SRC_BIT])
                evt = match_w[2*p+1];
            else
                evt = match_w[2*p];
            flop_d[p] = flop_q[p];
            if (fc[TMR_FLOPC_INV_BIT] && evt)
                flop_d[p] = !flop_q[p];
            if (flopc_wr)
            begin
                case (tmr_ff_cmd_t'(field2(reg_wdata,
                        p * TMR_FLOPC_PAIR_STRIDE + TMR_FLOPC_CMD_LSB)))
                    TMR_FF_TOGGLE: flop_d[p] = !flop_q[p];
                    TMR_FF_SET:    flop_d[p] = 1'b1;
                    TMR_FF_CLEAR:  flop_d[p] = 1'b0;
                    default:       flop_d[p] = flop_d[p];
                endcase
            end
        end
    end

    // interrupts and read data
    always_comb
    begin
        irq_d   = match_w;
        rdata_d = TMR_ZERO;
        if (reg_rd)
        begin
            case (reg_addr)
                TMR_ADDR_RUN:    rdata_d = run_q;
                TMR_ADDR_MODE_A: rdata_d = mode_q[0];
                TMR_ADDR_MODE_B: rdata_d = mode_q[1];
                TMR_ADDR_FLOPC:  rdata_d = flopc_q;
                TMR_ADDR_BUFC:   rdata_d = bufc_q;
                TMR_ADDR_STATUS: rdata_d = TMR_DW'(flop_q);
                default:         rdata_d = TMR_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flop_q  <= '0;
            irq_q   <= '0;
            rdata_q <= TMR_ZERO;
        end
        else
        begin
            flop_q  <= flop_d;
            irq_q   <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata         = rdata_q;
    assign timer0_irq        = irq_q[0];
    assign timer1_irq        = irq_q[1];
    assign timer2_irq        = irq_q[2];
    assign timer3_irq        = irq_q[3];
    assign pair_a_output_pin = flop_q[0];
    assign pair_b_output_pin = flop_q[1];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_cmd_a(logic [1:0] c);
        flopc_wr && field2(reg_wdata, TMR_FLOPC_CMD_LSB) == c;
    endsequence

    sequence s_match_a_inv;
        !flopc_wr && !cycuse_w[0] && flopc_q[TMR_FLOPC_INV_BIT] &&
        !flopc_q[TMR_FLOPC_SRC_BIT] && match_w[0];
    endsequence

    AST_FLOP_TOGGLE_CMD: assert property (
        s_cmd_a(TMR_FF_TOGGLE) |=> pair_a_output_pin != $past(flop_q[0]))
        else $error("toggle command did not invert flop");
    AST_FLOP_SET_CMD: assert property (
        s_cmd_a(TMR_FF_SET) |=> pair_a_output_pin)
        else $error("set command did not set flop");
    AST_FLOP_CLEAR_CMD: assert property (
        s_cmd_a(TMR_FF_CLEAR) |=> !pair_a_output_pin)
        else $error("clear command did not clear flop");
    AST_MATCH_TOGGLE: assert property (
        s_match_a_inv |=> pair_a_output_pin != $past(flop_q[0]) && timer0_irq)
        else $error("match did not toggle flop with interrupt");
    AST_IRQ_PULSE: assert property (
        match_w[1] ##1 !match_w[1] |=> !timer1_irq)
        else $error("interrupt longer than one cycle");
    AST_PRESC_HELD: assert property (
        !prun ##1 !prun |-> presc_q == '0 && !t_div8)
        else $error("prescaler not cleared while stopped");
    AST_PERIOD_READ_ZERO: assert property (
        reg_rd && reg_addr == TMR_ADDR_PERIOD1 |=> reg_rdata == TMR_ZERO)
        else $error("period register read back");
    AST_CASCADE_TICK: assert property (
        field2(mode_q[0], TMR_MODE_UCLK_LSB) == 2'h0 |->
            tick_w[1] == match_w[0])
        else $error("timer 1 tick not from timer 0 match");
    AST_BUF_RESET: assert property (
        $rose(reset_n) |-> bufc_q == TMR_BUFC_RST)
        else $error("buffer enables not cleared by reset");
endmodule
`default_nettype wire

// ==== tb/test_eight_bit_interval_timers.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_eight_bit_interval_timers;
    import tmr_pkg::*;
    logic       sys_clk;
    logic       reset_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    wire  [3:0] irq;
    logic       pin_a;
    logic       pin_b;
    logic       p;
    int         n;
    int         fail_count;
    int         check_count;

    tmr_top u_tmr_top (
        .sys_clk           (sys_clk),
        .reset_n           (reset_n),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .reg_wr            (reg_wr),
        .reg_rd            (reg_rd),
        .reg_rdata         (reg_rdata),
        .timer0_irq        (irq[0]),
        .timer1_irq        (irq[1]),
        .timer2_irq        (irq[2]),
        .timer3_irq        (irq[3]),
        .pair_a_output_pin (pin_a),
        .pair_b_output_pin (pin_b)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic check(input string w, input logic [15:0] s,
                         input logic [15:0] e);
        check_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", w, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check("rdata", {8'h00, reg_rdata}, {8'h00, e});
    endtask

    // counts cycles up to the next interrupt pulse of timer i
    task automatic wait_irq(input int i, input int lim);
        logic h;
        h = irq[i];
        n = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n == 1 && h === 1'b1)
                check("irq pulse", 16'(irq[i]), 16'h0000);
        end
        while (irq[i] !== 1'b1 && n < lim);
    endtask

    task automatic t_reset();
        rd(TMR_ADDR_RUN, TMR_RUN_RST);
        rd(TMR_ADDR_FLOPC, TMR_FLOPC_RST);
        rd(TMR_ADDR_BUFC, TMR_BUFC_RST);
        rd(8'h30, 8'h00);
        check("pin_a", 16'(pin_a), 16'h0000);
        $display("t_reset done");
    endtask

    task automatic t_interval();
        for (int k = 0; k < TMR_NCH; k++)
            wr(TMR_PERIOD_ADDR[k], 8'h02);
        for (int k = 0; k < TMR_NCH; k++)
            rd(TMR_PERIOD_ADDR[k], 8'h00);
        wr(TMR_ADDR_FLOPC, 8'h37);
        wr(TMR_ADDR_RUN, 8'h81);
        wait_irq(0, 200);
        p = pin_a;
        wait_irq(0, 200);
        check("t0 gap", 16'(n), 16'd16);
        check("pin_a", 16'(pin_a), 16'(!p));
        $display("t_interval done");
    endtask

    task automatic t_stop_zero();
        wr(TMR_ADDR_RUN, 8'h80);
        repeat (2) @(posedge sys_clk);
        wait_irq(0, 100);
        check("t0 stopped", 16'(n), 16'd100);
        wr(TMR_ADDR_PERIOD0, 8'h00);
        wr(TMR_ADDR_RUN, 8'h81);
        wait_irq(0, 3000);
        wait_irq(0, 3000);
        check("t0 zero gap", 16'(n), 16'd2048);
        $display("t_stop_zero done");
    endtask

    task automatic t_cascade();
        wr(TMR_ADDR_RUN, 8'h80);
        wr(TMR_ADDR_PERIOD0, 8'h02);
        wr(TMR_ADDR_PERIOD1, 8'h03);
        wr(TMR_ADDR_MODE_A, 8'h00);
        wr(TMR_ADDR_RUN, 8'h83);
        wait_irq(1, 200);
        wait_irq(1, 200);
        check("t1 gap", 16'(n), 16'd48);
        $display("t_cascade done");
    endtask

    task automatic t_pair_b();
        wr(TMR_ADDR_PERIOD2, 8'h04);
        wr(TMR_ADDR_PERIOD3, 8'h01);
        wr(TMR_ADDR_MODE_B, 8'h04);
        wr(TMR_ADDR_FLOPC, 8'hf3);
        wr(TMR_ADDR_RUN, 8'h8f);
        wait_irq(2, 200);
        wait_irq(2, 200);
        check("t2 gap", 16'(n), 16'd32);
        wait_irq(3, 200);
        p = pin_b;
        wait_irq(3, 200);
        check("t3 gap", 16'(n), 16'd8);
        check("pin_b", 16'(pin_b), 16'(!p));
        $display("t_pair_b done");
    endtask

    task automatic t_flop();
        wr(TMR_ADDR_RUN, 8'h00);
        wr(TMR_ADDR_FLOPC, 8'h32);
        check("pin_a", 16'(pin_a), 16'h0000);
        wr(TMR_ADDR_FLOPC, 8'h31);
        check("pin_a", 16'(pin_a), 16'h0001);
        wr(TMR_ADDR_FLOPC, 8'h13);
        check("pin_b", 16'(pin_b), 16'h0001);
        wr(TMR_ADDR_FLOPC, 8'h03);
        check("pin_b", 16'(pin_b), 16'h0000);
        rd(TMR_ADDR_STATUS, 8'h01);
        wr(TMR_ADDR_FLOPC, 8'h30);
        check("pin_a", 16'(pin_a), 16'h0000);
        $display("t_flop done");
    endtask

    task automatic t_buffer();
        // pwm n = 6: buffered value takes over at the 64-tick cycle end
        wr(TMR_ADDR_PERIOD0, 8'h10);
        wr(TMR_ADDR_BUFC, 8'h01);
        wr(TMR_ADDR_PERIOD0, 8'h20);
        wr(TMR_ADDR_MODE_A, 8'h30);
        wr(TMR_ADDR_RUN, 8'h81);
        wait_irq(0, 1000);
        wait_irq(0, 1000);
        check("pwm gap", 16'(n), 16'd640);
        // ppg: the upper period sets an 8-tick cycle
        wr(TMR_ADDR_RUN, 8'h80);
        wr(TMR_ADDR_BUFC, 8'h00);
        wr(TMR_ADDR_PERIOD0, 8'h03);
        wr(TMR_ADDR_PERIOD1, 8'h08);
        wr(TMR_ADDR_BUFC, 8'h01);
        wr(TMR_ADDR_PERIOD0, 8'h05);
        wr(TMR_ADDR_MODE_A, 8'h20);
        wr(TMR_ADDR_RUN, 8'h81);
        wait_irq(0, 200);
        wait_irq(0, 200);
        check("ppg gap", 16'(n), 16'd80);
        $display("t_buffer done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        fail_count  = 0;
        check_count = 0;
        reset_n     = 1'b0;
        reg_addr    = 8'h00;
        reg_wdata   = 8'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset();
        t_interval();
        t_stop_zero();
        t_cascade();
        t_pair_b();
        t_flop();
        t_buffer();
        print_verdict();
    end

    initial
    begin
        repeat (30000) @(posedge sys_clk);
        fail_count++;
        $display("[FAIL] watchdog expired");
        print_verdict();
    end
endmodule
`default_nettype wire
